// >>> verilog/program_space_access.sv
// Program space access: table reads/writes, visibility window, row programming.
// Assumes the CPU waits on o_stall and o_req_ready, and the flash array
// answers o_fl_rd_addr combinationally on i_fl_rdata in the same cycle.
// Overview of operation
// R1: 24-bit program space beside 16-bit data space
// R2: Table ops reach every program word byte
// R3: Window reads only, low word returned
// R4: Table address is page register over offset
// R5: Page register top bit selects configuration
// R6: Window address from visibility page plus offset
// R7: Window forces address bit 23 low
// R8: Window drops offset bit 15, uses page bit
// R9: Rows of 64 words; row or word programming
// R10: Erase covers pages of eight rows
// R11: Pages and rows aligned from memory start
// R12: Software fills buffers from one aligned group
// R13: Software issues 64 low and high writes
// R14: Table write fills buffer in two cycles
// R15: Each row programmed by its own start
// R16: Processor stalls during program or erase
// R17: Row write lasts 11064 oscillator cycles
// R18: Start bit self-clears on completion
// R19: Software writes unlock keys before start
// R20: Busy held until oscillator count completes
`default_nettype none
module program_space_access
    import flash_access_pkg::*;
#(
    parameter osc_cnt_t ROW_LEN   = osc_cnt_t'(ROW_OSC_CYCLES),
    parameter osc_cnt_t WORD_LEN  = osc_cnt_t'(WORD_OSC_CYCLES),
    parameter osc_cnt_t ERASE_LEN = osc_cnt_t'(ERASE_OSC_CYCLES)
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire cpu_req_t    i_req,
    input  wire logic        i_table_page_we,
    input  wire logic [7:0]  i_table_page_wdata,
    input  wire logic        i_vispag_we,
    input  wire logic [7:0]  i_vispag_wdata,
    input  wire logic        i_ctl_we,
    input  wire logic [15:0] i_ctl_wdata,
    input  wire logic        i_key_we,
    input  wire logic [7:0]  i_key_wdata,
    input  wire logic [23:0] i_fl_rdata,
    output logic             o_req_ready,
    output logic             o_tbl_wr_ack,
    output logic [15:0]      o_rdata,
    output logic             o_rvalid,
    output logic             o_fl_rd,
    output prog_addr_t       o_fl_rd_addr,
    output logic             o_fl_cfg_sel,
    output flash_cmd_t       o_fl_cmd,
    output logic             o_stall,
    output logic [15:0]      o_flash_ctl,
    output logic [7:0]       o_table_page,
    output logic [7:0]       o_vis_page
);
    typedef enum logic {ST_IDLE, ST_RUN} state_t;

    state_t            state_r, state_nxt;
    logic [7:0]        table_page_r, table_page_nxt, vis_page_r, vis_page_nxt;
    logic [15:0]       ctl_r, ctl_nxt;
    logic              key_stage_r, key_stage_nxt, armed_r, armed_nxt;
    osc_cnt_t          cnt_r, cnt_nxt, op_len;
    prog_addr_t        target_r, target_nxt;
    logic              tw_pend_r, tw_pend_nxt, tw_hi_r, tw_hi_nxt, tw_byte_r, tw_byte_nxt;
    logic [15:0]       tw_adr_r, tw_adr_nxt, tw_data_r, tw_data_nxt;
    logic              rd_r, rd_nxt, rv_r, rv_nxt, rd_byte_r, rd_byte_nxt, cfg_r, cfg_nxt;
    logic              rd_ea0_r, rd_ea0_nxt, rd_win_r, rd_win_nxt;
    req_op_t           rd_kind_r, rd_kind_nxt;
    prog_addr_t        rd_addr_r, rd_addr_nxt;
    logic [15:0]       rdata_r, rdata_nxt, req_addr;
    flash_cmd_t        cmd_r, cmd_nxt;
    logic [WORD_W-1:0] buf_mem [ROW_WORDS];
    logic              buf_we;
    logic [ROW_IDX_W-1:0] buf_idx, run_idx;
    logic [WORD_W-1:0] buf_wdata, buf_wmask;
    logic              osc_tick, accept, is_rd, is_wr;

    // =====================================================================
    // Oscillator-rate enable, running only while an operation is timed
    osc_tick_gen #(
        .INC (OSC_KHZ),
        .MOD (CLK_KHZ),
        .AW  (ACC_W)
    ) u_osc_tick (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_en    (state_r == ST_RUN),
        .o_tick  (osc_tick)
    );

    // =====================================================================
    // Request decode; a stalled CPU cannot issue anything
    // R16: stall refuses requests
    assign o_req_ready  = (state_r == ST_IDLE) && !tw_pend_r;
    assign accept       = i_req.valid && o_req_ready;
    assign req_addr     = i_req.effective_address;
    assign is_rd        = (i_req.op == OP_RD_LO) || (i_req.op == OP_RD_HI);
    assign is_wr        = (i_req.op == OP_WR_LO) || (i_req.op == OP_WR_HI);
    assign o_tbl_wr_ack = tw_pend_r;
    assign o_stall      = (state_r == ST_RUN);

    // =====================================================================
    // Read path: address formation, then lane selection one cycle later
    // R1: 24-bit words under 16-bit data
    always_comb begin
        rd_nxt      = 1'b0;
        rv_nxt      = rd_r;
        rd_kind_nxt = rd_kind_r;
        rd_byte_nxt = rd_byte_r;
        rd_ea0_nxt  = rd_ea0_r;
        rd_win_nxt  = rd_win_r;
        rd_addr_nxt = rd_addr_r;
        cfg_nxt     = cfg_r;
        rdata_nxt   = rdata_r;
        if (accept && (is_rd || i_req.op == OP_DS_RD)) begin
            rd_nxt      = 1'b1;
            rd_kind_nxt = i_req.op;
            rd_byte_nxt = i_req.byte_op;
            rd_ea0_nxt  = req_addr[0];
            rd_win_nxt  = req_addr[WIN_SEL_BIT];
            if (is_rd) begin
                // R4: page register above offset
                rd_addr_nxt = {table_page_r, req_addr[15:1], 1'b0};
                // R5: top page bit selects configuration
                cfg_nxt     = table_page_r[CFG_SEL_BIT];
            end else begin
                // R6: visibility page joined to offset
                // R7: bit 23 forced low
                // R8: page bit 0 replaces bit 15
                rd_addr_nxt = {1'b0, vis_page_r, req_addr[14:1], 1'b0};
                cfg_nxt     = 1'b0;
            end
        end
        if (rd_r) begin
            case (rd_kind_r)
                // R2: low word or either low byte
                OP_RD_LO: rdata_nxt = !rd_byte_r ? i_fl_rdata[15:0] :
                                      rd_ea0_r ? {8'h00, i_fl_rdata[15:8]} :
                                                 {8'h00, i_fl_rdata[7:0]};
                // R2: upper byte, odd phantom byte reads zero
                OP_RD_HI: rdata_nxt = (rd_byte_r && rd_ea0_r) ? 16'h0000 :
                                      {8'h00, i_fl_rdata[23:16]};
                // R3: window returns low word only
                OP_DS_RD: rdata_nxt = !rd_win_r ? 16'h0000 :
                                      !rd_byte_r ? i_fl_rdata[15:0] :
                                      rd_ea0_r ? {8'h00, i_fl_rdata[15:8]} :
                                                 {8'h00, i_fl_rdata[7:0]};
                default:  rdata_nxt = 16'h0000;
            endcase
        end
    end

    // Flash is only strobed for table reads and window hits
    assign o_fl_rd      = rd_r && (rd_kind_r != OP_DS_RD || rd_win_r);
    assign o_fl_rd_addr = rd_addr_r;
    assign o_fl_cfg_sel = cfg_r;
    assign o_rdata      = rdata_r;
    assign o_rvalid     = rv_r;

    // =====================================================================
    // Table write: latch in the first cycle, fill the buffer in the second
    always_comb begin
        tw_pend_nxt = 1'b0;
        tw_hi_nxt   = tw_hi_r;
        tw_byte_nxt = tw_byte_r;
        tw_adr_nxt  = tw_adr_r;
        tw_data_nxt = tw_data_r;
        target_nxt  = target_r;
        if (accept && is_wr) begin
            tw_pend_nxt = 1'b1;
            tw_hi_nxt   = (i_req.op == OP_WR_HI);
            tw_byte_nxt = i_req.byte_op;
            tw_adr_nxt  = req_addr;
            tw_data_nxt = i_req.wdata;
            target_nxt  = {table_page_r, req_addr[15:1], 1'b0};
        end
    end

    // Holding buffer lane masks; the flash array itself is untouched here
    always_comb begin
        buf_idx   = tw_adr_r[ROW_IDX_W:1];
        buf_we    = 1'b0;
        buf_wdata = '0;
        buf_wmask = '0;
        // R14: buffer-only write in second cycle
        if (tw_pend_r) begin
            buf_we = 1'b1;
            if (tw_hi_r) begin
                buf_wdata = {tw_data_r[7:0], 16'h0000};
                buf_wmask = (tw_byte_r && tw_adr_r[0]) ? 24'h000000 : 24'hFF0000;
            end else if (tw_byte_r) begin
                buf_wdata = {8'h00, tw_data_r[7:0], tw_data_r[7:0]};
                buf_wmask = tw_adr_r[0] ? 24'h00FF00 : 24'h0000FF;
            end else begin
                buf_wdata = {8'h00, tw_data_r};
                buf_wmask = 24'h00FFFF;
            end
        end
    end

    // Buffer array has no reset; software loads it before every program
    always_ff @(posedge i_clk) begin
        if (buf_we) begin
            buf_mem[buf_idx] <= (buf_mem[buf_idx] & ~buf_wmask) | (buf_wdata & buf_wmask);
        end
    end

    // =====================================================================
    // Page registers, unlock sequence, control register and the timed run
    always_comb begin
        case (ctl_r[1:0])
            MODE_ROW:   op_len = ROW_LEN;
            MODE_ERASE: op_len = ERASE_LEN;
            default:    op_len = WORD_LEN;
        endcase
    end

    always_comb begin
        table_page_nxt = i_table_page_we ? i_table_page_wdata : table_page_r;
        vis_page_nxt   = i_vispag_we ? i_vispag_wdata : vis_page_r;
        key_stage_nxt  = key_stage_r;
        armed_nxt      = armed_r;
        ctl_nxt        = ctl_r;
        state_nxt      = state_r;
        cnt_nxt        = cnt_r;
        // Unlock needs the two keys on consecutive key writes
        if (i_key_we) begin
            key_stage_nxt = (i_key_wdata == KEY_FIRST);
            armed_nxt     = key_stage_r && (i_key_wdata == KEY_SECOND);
        end
        case (state_r)
            ST_IDLE: begin
                if (i_ctl_we) begin
                    ctl_nxt   = i_ctl_wdata & CTL_WMASK;
                    armed_nxt = 1'b0;
                    // R15: one start per row
                    if (i_ctl_wdata[CTL_WR_BIT] && i_ctl_wdata[CTL_WREN_BIT] &&
                        armed_r && i_ctl_wdata[1:0] != MODE_NONE) begin
                        ctl_nxt[CTL_WR_BIT] = 1'b1;
                        state_nxt           = ST_RUN;
                        cnt_nxt             = '0;
                    end
                end
            end
            ST_RUN: begin
                if (osc_tick) begin
                    // R17: length counted in oscillator cycles
                    // R20: busy until count reaches length
                    if (cnt_r == op_len - osc_cnt_t'(1)) begin
                        state_nxt = ST_IDLE;
                        cnt_nxt   = '0;
                        // R18: start bit self-clears
                        ctl_nxt[CTL_WR_BIT] = 1'b0;
                    end else begin
                        cnt_nxt = cnt_r + osc_cnt_t'(1);
                    end
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // =====================================================================
    // Array commands, at most one per oscillator period during the run
    assign run_idx = cnt_r[ROW_IDX_W-1:0];
    always_comb begin
        cmd_nxt = '0;
        if (state_r == ST_RUN && osc_tick) begin
            cmd_nxt.cfg = target_r[PROG_AW-1];
            case (ctl_r[1:0])
                // R9: whole row, 64 words
                // R11: row base aligned
                MODE_ROW: if (cnt_r < osc_cnt_t'(ROW_WORDS)) begin
                    cmd_nxt.wr   = 1'b1;
                    cmd_nxt.addr = (target_r & ROW_MASK) | prog_addr_t'({run_idx, 1'b0});
                    cmd_nxt.data = buf_mem[run_idx];
                end
                // R9: single word at last written address
                MODE_WORD: if (cnt_r == '0) begin
                    cmd_nxt.wr   = 1'b1;
                    cmd_nxt.addr = target_r;
                    cmd_nxt.data = buf_mem[target_r[ROW_IDX_W:1]];
                end
                // R10: eight-row page erase
                // R11: page base aligned
                MODE_ERASE: if (cnt_r == '0) begin
                    cmd_nxt.erase = 1'b1;
                    cmd_nxt.addr  = target_r & PAGE_MASK;
                end
                default: cmd_nxt = '0;
            endcase
        end
    end

    // =====================================================================
    // State registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_IDLE;        table_page_r <= '0;        vis_page_r <= '0;
            ctl_r <= CTL_RESET;        key_stage_r <= 1'b0;       armed_r <= 1'b0;
            cnt_r <= '0;               target_r <= '0;            tw_pend_r <= 1'b0;
            tw_hi_r <= 1'b0;           tw_byte_r <= 1'b0;         tw_adr_r <= '0;
            tw_data_r <= '0;           rd_r <= 1'b0;              rv_r <= 1'b0;
            rd_kind_r <= OP_RD_LO;     rd_byte_r <= 1'b0;         rd_ea0_r <= 1'b0;
            rd_win_r <= 1'b0;          rd_addr_r <= '0;           cfg_r <= 1'b0;
            rdata_r <= '0;             cmd_r <= '0;
        end else begin
            state_r <= state_nxt;      table_page_r <= table_page_nxt; vis_page_r <= vis_page_nxt;
            ctl_r <= ctl_nxt;          key_stage_r <= key_stage_nxt;   armed_r <= armed_nxt;
            cnt_r <= cnt_nxt;          target_r <= target_nxt;    tw_pend_r <= tw_pend_nxt;
            tw_hi_r <= tw_hi_nxt;      tw_byte_r <= tw_byte_nxt;  tw_adr_r <= tw_adr_nxt;
            tw_data_r <= tw_data_nxt;  rd_r <= rd_nxt;            rv_r <= rv_nxt;
            rd_kind_r <= rd_kind_nxt;  rd_byte_r <= rd_byte_nxt;  rd_ea0_r <= rd_ea0_nxt;
            rd_win_r <= rd_win_nxt;    rd_addr_r <= rd_addr_nxt;  cfg_r <= cfg_nxt;
            rdata_r <= rdata_nxt;      cmd_r <= cmd_nxt;
        end
    end

    assign o_fl_cmd     = cmd_r;
    assign o_flash_ctl  = ctl_r;
    assign o_table_page = table_page_r;
    assign o_vis_page   = vis_page_r;

    // =====================================================================
    // Assertions and covers
    logic [7:0] row_wr_cnt;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) row_wr_cnt <= '0;
        else if (state_r == ST_IDLE) row_wr_cnt <= '0;
        else if (cmd_r.wr) row_wr_cnt <= row_wr_cnt + 8'h01;
    end

    AST_TBL_ADDR: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R4
        accept && is_rd |=> o_fl_rd && o_fl_rd_addr[23:16] == $past(table_page_r)
            && o_fl_rd_addr[15:1] == $past(req_addr[15:1]))
        else $error("table address not page over offset");
    AST_CFG_SEL: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R5
        o_fl_rd |-> o_fl_cfg_sel == o_fl_rd_addr[23])
        else $error("configuration select disagrees with page bit");
    AST_WIN_ADDR: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R8
        accept && i_req.op == OP_DS_RD && req_addr[15] |=>
            o_fl_rd && o_fl_rd_addr[22:15] == $past(vis_page_r)
            && o_fl_rd_addr[14:1] == $past(req_addr[14:1]))
        else $error("window address formed wrongly");
    AST_WIN_USER: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R7
        o_fl_rd && rd_kind_r == OP_DS_RD |-> !o_fl_rd_addr[23] && !o_fl_cfg_sel)
        else $error("window reached configuration memory");
    AST_WIN_LOW: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R3
        o_fl_rd && rd_kind_r == OP_DS_RD && !rd_byte_r |=> o_rvalid
            && o_rdata == $past(i_fl_rdata[15:0]))
        else $error("window did not return low word");
    AST_HI_BYTE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
        o_fl_rd && rd_kind_r == OP_RD_HI && !rd_byte_r |=>
            o_rdata == {8'h00, $past(i_fl_rdata[23:16])})
        else $error("upper byte not returned");
    AST_TW_TWO: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R14
        accept && is_wr |=> o_tbl_wr_ack && !o_req_ready ##1 !o_tbl_wr_ack && !cmd_r.wr)
        else $error("table write not two cycles");
    AST_STALL: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R16
        o_stall |-> !o_req_ready && o_flash_ctl[CTL_WR_BIT])
        else $error("stall without running operation");
    AST_WR_CLR: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R18
        $fell(o_stall) |-> !o_flash_ctl[CTL_WR_BIT] && $past(cnt_r) == $past(op_len) - 1)
        else $error("start bit not cleared at end of count");
    AST_ROW_64: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R9
        $fell(o_stall) && $past(ctl_r[1:0]) == MODE_ROW |-> row_wr_cnt == 8'h40)
        else $error("row write did not emit 64 words");
    AST_ALIGN: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
        cmd_r.erase |-> cmd_r.addr[9:0] == 10'h000)
        else $error("erase page not aligned");
    AST_BUSY_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R20
        $rose(o_stall) |-> o_stall [*8])
        else $error("busy dropped early");

    COV_ROW: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        $fell(o_stall) && $past(ctl_r[1:0]) == MODE_ROW);
    COV_ERASE: cover property (@(posedge i_clk) disable iff (!i_rst_n) cmd_r.erase);
    COV_WIN: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        o_fl_rd && rd_kind_r == OP_DS_RD);
    COV_TW: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_tbl_wr_ack);
endmodule : program_space_access
`default_nettype wire

// >>> include/flash_access_pkg.sv
// Constants, field layouts and carrier types for the program space access block.
// Assumes a single 250 MHz clock and an internal fast oscillator near 7.37 MHz.
`default_nettype none
package flash_access_pkg;
    // =====================================================================
    // Widths
    localparam int PROG_AW    = 24;
    localparam int DATA_W     = 16;
    localparam int PAGE_W     = 8;
    localparam int WORD_W     = 24;
    localparam int ROW_WORDS  = 64;
    localparam int ROW_IDX_W  = 6;
    localparam int OSC_CNT_W  = 16;
    typedef logic [PROG_AW-1:0]   prog_addr_t;
    typedef logic [OSC_CNT_W-1:0] osc_cnt_t;

    // =====================================================================
    // Address formation
    localparam int         WIN_SEL_BIT   = 15;
    localparam int         CFG_SEL_BIT   = 7;
    localparam prog_addr_t ROW_MASK      = 24'hFFFF80;   // 64 words x 2 address units
    localparam prog_addr_t PAGE_MASK     = 24'hFFFC00;   // 8 rows

    // =====================================================================
    // Flash control register layout and unlock keys
    localparam int          CTL_WR_BIT   = 15;
    localparam int          CTL_WREN_BIT = 14;
    localparam logic [15:0] CTL_RESET    = 16'h0000;
    localparam logic [15:0] CTL_WMASK    = 16'h4003;
    localparam logic [1:0]  MODE_NONE    = 2'h0;
    localparam logic [1:0]  MODE_WORD    = 2'h1;
    localparam logic [1:0]  MODE_ROW     = 2'h2;
    localparam logic [1:0]  MODE_ERASE   = 2'h3;
    localparam logic [7:0]  KEY_FIRST    = 8'h55;
    localparam logic [7:0]  KEY_SECOND   = 8'hAA;

    // =====================================================================
    // Timing
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int CLK_KHZ         = 1000000000 / CLK_PERIOD_PS;
    localparam int OSC_KHZ         = 7370;
    localparam int ACC_W           = 18;
    localparam int ROW_OSC_CYCLES  = 11064;
    localparam int WORD_OSC_CYCLES = 1000;
    localparam int ERASE_OSC_CYCLES = 20000;

    // =====================================================================
    // Carriers
    typedef enum logic [2:0] {OP_RD_LO, OP_RD_HI, OP_WR_LO, OP_WR_HI, OP_DS_RD} req_op_t;
    typedef struct packed {
        logic              valid;
        req_op_t           op;
        logic              byte_op;
        logic [DATA_W-1:0] effective_address;
        logic [DATA_W-1:0] wdata;
    } cpu_req_t;
    typedef struct packed {
        logic              wr;
        logic              erase;
        logic              cfg;
        prog_addr_t        addr;
        logic [WORD_W-1:0] data;
    } flash_cmd_t;
endpackage : flash_access_pkg
`default_nettype wire

// >>> verilog/osc_tick_gen.sv
// Fractional divider giving one enable pulse per internal oscillator period.
// Assumes the enable is held for the whole timed operation.
`default_nettype none
module osc_tick_gen #(
    parameter int INC = 1,
    parameter int MOD = 2,
    parameter int AW  = 18
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_en,
    output logic      o_tick
);
    logic [AW-1:0] acc_r;
    logic [AW-1:0] acc_nxt;
    logic          tick_r;
    logic          tick_nxt;
    logic [AW:0]   sum;

    // =====================================================================
    // Phase accumulator; restarts at zero so every operation starts aligned
    assign sum = {1'b0, acc_r} + (AW+1)'(INC);
    always_comb begin
        acc_nxt  = '0;
        tick_nxt = 1'b0;
        if (i_en) begin
            if (sum >= (AW+1)'(MOD)) begin
                acc_nxt  = AW'(sum - (AW+1)'(MOD));
                tick_nxt = 1'b1;
            end else begin
                acc_nxt = sum[AW-1:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            acc_r  <= acc_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign o_tick = tick_r;
endmodule : osc_tick_gen
`default_nettype wire

// >>> bench/flash_model.sv
// Flash array stand-in answering a read address with a fixed pattern.
// Assumes reads are answered in the same cycle, as the block expects.
`default_nettype none
module flash_model
    import flash_access_pkg::*;
(
    input  wire logic       i_rd,
    input  wire prog_addr_t i_addr,
    output logic [23:0]     o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] pat;
    // ==========
    // full 24-bit word
    assign pat = {i_addr[23:16] ^ i_addr[7:0], i_addr[15:0] ^ 16'hA5C3};
    // Inverse when idle, so a stale value never matches
    assign o_data = i_rd ? pat : ~pat;
endmodule : flash_model
`default_nettype wire

// >>> bench/program_space_access_bench.sv
// Bench: table and window reads, buffer loads, program and erase runs.
// Assumes the flash model answers reads combinationally.
`default_nettype none
module program_space_access_bench import flash_access_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 0, i_rst_n = 0, tw = 0, vw = 0, cw = 0, kw = 0, bo = 0;
    logic [7:0]  td = 0, vd = 0, kd = 0, page, vpage, tpo, vpo, hi [64];
    logic [15:0] cd = 0, adr, base, rdat, fctl, lo [64];
    logic [23:0] fl_d, a;
    logic        rdy, ack, rv, frd, cfg, stall;
    prog_addr_t  fa;
    flash_cmd_t  cmd;
    cpu_req_t    req = '0;
    int          errors = 0, num_checks = 0, cycles = 0, n, k, i;
    program_space_access #(.ROW_LEN(osc_cnt_t'(70)), .WORD_LEN(osc_cnt_t'(10)),
        .ERASE_LEN(osc_cnt_t'(10))) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req),
        .i_table_page_we(tw), .i_table_page_wdata(td), .i_vispag_we(vw), .i_vispag_wdata(vd),
        .i_ctl_we(cw), .i_ctl_wdata(cd), .i_key_we(kw), .i_key_wdata(kd),
        .i_fl_rdata(fl_d), .o_req_ready(rdy), .o_tbl_wr_ack(ack), .o_rdata(rdat),
        .o_rvalid(rv), .o_fl_rd(frd), .o_fl_rd_addr(fa), .o_fl_cfg_sel(cfg),
        .o_fl_cmd(cmd), .o_stall(stall), .o_flash_ctl(fctl), .o_table_page(tpo),
        .o_vis_page(vpo));
    flash_model u_fl (.i_rd(frd), .i_addr(fa), .o_data(fl_d));
    // ==========
    // Shared checking and driving tasks
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    // Register strobes: 0 table page, 1 window page, 2 key, 3 control
    task automatic wr(input int r, input logic [15:0] d);
        @(posedge i_clk);
        {td, vd, kd, cd} <= {d[7:0], d[7:0], d[7:0], d};
        {tw, vw, kw, cw} <= {r == 0, r == 1, r == 2, r == 3};
        @(posedge i_clk);
        {tw, vw, kw, cw} <= 4'h0;
        #1;
    endtask : wr
    task automatic rq(input req_op_t op, input logic [15:0] e, input logic [15:0] w);
        @(posedge i_clk);
        req <= '{1'b1, op, bo, e, w};
        @(posedge i_clk);
        req.valid <= 1'b0;
        #1;
    endtask : rq
    function automatic logic [15:0] exp_d(req_op_t op, logic [15:0] e, logic [23:0] x);
        logic [23:0] f;
        f = {x[23:16] ^ x[7:0], x[15:0] ^ 16'hA5C3};
        if (op == OP_RD_HI) return (bo && e[0]) ? 16'h0000 : {8'h00, f[23:16]};
        if (op == OP_DS_RD && !e[15]) return 16'h0000;
        if (bo) return {8'h00, e[0] ? f[15:8] : f[7:0]};
        return f[15:0];
    endfunction : exp_d
    // Bounded wait for the read answer; unwanted window reads flagged
    task automatic rd(input req_op_t op, input logic [15:0] e);
        logic got;
        logic [23:0] x;
        got = 0;
        x = (op == OP_DS_RD) ? {1'b0, vpage, e[14:1], 1'b0} : {page, e[15:1], 1'b0};
        rq(op, e, 16'h0000);
        repeat (3) begin
            if (frd === 1'b1) begin
                chk(fa, x);
                chk({cfg, op == OP_DS_RD && !e[15]}, {op != OP_DS_RD && page[7], 1'b0});
            end
            if (rv === 1'b1 && !got) begin
                got = 1;
                chk(rdat, exp_d(op, e, x));
            end
            @(posedge i_clk);
            #1;
        end
        chk(got, 1'b1);
    endtask : rd
    initial forever #2 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end
    // ==========
    // Main sequence: reset, reads, refused start, then each mode
    initial begin
        k = $urandom(10078);
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        #1;
        chk({rdy, stall, fctl}, {1'b1, 1'b0, 16'h0000});
        for (k = 0; k < 12; k++) begin
            page = (k == 0) ? 8'hFF : 8'($urandom);
            vpage = (k == 0) ? 8'hFF : 8'($urandom);
            bo = k[0];
            adr = (k == 0) ? 16'hFFFE : 16'($urandom) & {15'h7FFF, bo};
            wr(0, {8'h00, page});
            wr(1, {8'h00, vpage});
            chk({tpo, vpo}, {page, vpage});
            rd(OP_RD_LO, adr);
            rd(OP_RD_HI, adr);
            rd(OP_DS_RD, adr);
            rd(OP_DS_RD, adr ^ 16'h8000);
        end
        bo = 1'b0;
        // Keys in the wrong order must not arm a start
        wr(2, 16'h00AA);
        wr(2, 16'h0055);
        wr(3, 16'hC002);
        chk({stall, fctl}, {1'b0, 16'h4002});
        for (k = 1; k < 4; k++) begin
            base = 16'($urandom) & 16'hFF80;
            for (i = 0; i < 64; i++) begin
                lo[i] = 16'($urandom);
                hi[i] = 8'($urandom);
                rq(OP_WR_LO, base + 16'(i * 2), lo[i]);
                chk({ack, rdy}, 2'b10);
                rq(OP_WR_HI, base + 16'(i * 2), {8'h00, hi[i]});
            end
            a = {page, base} + 24'h00007E;
            wr(2, 16'h0055);
            wr(2, 16'h00AA);
            wr(3, {2'b11, 12'h000, 2'(k)});
            chk(stall, 1'b1);
            n = 0;
            i = 0;
            while (stall === 1'b1) begin
                i++;
                if (cmd.wr === 1'b1) begin
                    chk(cmd.addr, (k == 2) ? (a & ROW_MASK) | 24'(n * 2) : a);
                    chk(cmd.data, (k == 2) ? {hi[n], lo[n]} : {hi[63], lo[63]});
                    n++;
                end
                if (cmd.erase === 1'b1) begin
                    chk(cmd.addr, a & PAGE_MASK);
                    n++;
                end
                @(posedge i_clk);
                #1;
            end
            chk({23'(n), fctl[15]}, {(k == 2) ? 23'd64 : 23'd1, 1'b0});
            chk(24'(i * OSC_KHZ / CLK_KHZ), (k == 2) ? 24'd70 : 24'd10);
        end
        final_report();
    end
endmodule : program_space_access_bench
`default_nettype wire
